// [logic/timer_ccr_defs.vh]
`ifndef TIMER_CCR_DEFS_VH
`define TIMER_CCR_DEFS_VH

// ********************************************************
// register indices (byte address is four times the index)
// ********************************************************
`define CTRL_ONE_INDEX 8'h2C
`define CTRL_TWO_INDEX 8'h2D
`define STATUS_INDEX 8'h2E

// ********************************************************
// timer_control_one fields
// ********************************************************
`define BIT_CAP1_IE 7
`define BIT_CAP2_IE 6
`define BIT_CMP1_IE 5
`define BIT_OVF_IE 4
`define BIT_CMP1_PIN 3
`define BIT_CAP1_EDGE 2
`define BIT_CAP2_EDGE 1
`define BIT_CMP1_LVL 0

// ********************************************************
// timer_control_two fields
// ********************************************************
`define BIT_CMP2_IE 5
`define BIT_CMP2_PIN 3
`define BIT_CMP2_LVL 0
`define CTRL_TWO_RESET 8'h00

// ********************************************************
// timer_status fields
// ********************************************************
`define BIT_CAP1_FLAG 7
`define BIT_CAP2_FLAG 6
`define BIT_CMP1_FLAG 5
`define BIT_OVF_FLAG 4
`define BIT_CAP1_LEVEL 3
`define BIT_CAP2_LEVEL 2
`define BIT_CMP2_FLAG 1

// ********************************************************
// timing and bus answers
// ********************************************************
`define PRESCALE_LAST 2'h3
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [logic/edge_detect.v]
`timescale 1ns/10ps

// ********************************************************
// selectable edge detector for one capture pin
// ********************************************************
module edge_detect (
    input wire aclk,
    input wire aresetn,
    input wire pin,
    input wire rising_sel,
    output reg edge_pulse
);

reg prev;

// previous level; no reset needed, it only follows the pin
always @(posedge aclk) begin
    prev <= pin;
end

// one-cycle pulse on the chosen edge polarity
always @(posedge aclk) begin
    if (!aresetn) begin
        edge_pulse <= 1'b0;
    end else if (rising_sel) begin
        edge_pulse <= pin & ~prev;
    end else begin
        edge_pulse <= ~pin & prev;
    end
end

endmodule // edge_detect

// [logic/status_flag.v]
`timescale 1ns/10ps

// ********************************************************
// sticky status flag with two-step clear
// ********************************************************
module status_flag (
    input wire aclk,
    input wire aresetn,
    input wire set_event,
    input wire arm_access,
    input wire clear_access,
    output reg flag
);

reg armed;

// an access that arms only counts while the flag is already set;
// the set wins over a clear landing in the same cycle
always @(posedge aclk) begin
    if (!aresetn) begin
        flag <= 1'b0;
        armed <= 1'b0;
    end else begin
        if (set_event) begin
            flag <= 1'b1;
        end else if (clear_access && armed) begin
            flag <= 1'b0;
        end
        if (clear_access || !flag) begin
            armed <= 1'b0;
        end else if (arm_access) begin
            armed <= 1'b1;
        end
    end
end

endmodule // status_flag

// [logic/timer_capture_compare_ctrl.v]
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "timer_ccr_defs.vh"

module timer_capture_compare_ctrl #(
    parameter ADDR_W = 12
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [ADDR_W-1:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    input wire capture_input_one,
    input wire capture_input_two,
    output reg capture_one_latch,
    output reg capture_two_latch,
    input wire compare_one_equal,
    input wire compare_two_equal,
    input wire compare_one_high_write,
    input wire compare_one_low_write,
    input wire compare_two_high_write,
    input wire compare_two_low_write,
    input wire capture_one_low_read,
    input wire capture_two_low_read,
    input wire counter_low_read,
    input wire counter_wrap,
    output reg counter_tick,
    output reg compare_output_one,
    output reg compare_output_one_oe,
    output reg compare_output_two,
    output reg compare_output_two_oe,
    output reg timer_irq
);

// ********************************************************
// declarations
// ********************************************************
// reset image of control two; single bits are taken from it, never the whole byte
localparam [7:0] CTRL_TWO_RST = `CTRL_TWO_RESET;
reg [1:0] prescale;
reg capture_one_irq_enable, capture_two_irq_enable, compare_one_irq_enable, compare_two_irq_enable;
reg overflow_irq_enable, compare_one_pin_enable, compare_two_pin_enable;
reg capture_one_edge_select, capture_two_edge_select, compare_one_level, compare_two_level;
reg compare_one_inhibit, compare_two_inhibit;
reg [7:0] next_rdata;
wire wr_take, rd_take, wr_lane, wr_hit_one, wr_hit_two, wr_hit_status, wr_mapped;
wire rd_hit_one, rd_hit_two, rd_hit_status, rd_mapped, status_read, status_write;
wire cap_one_edge, cap_two_edge, cmp_one_match, cmp_two_match;
wire capture_one_flag, capture_two_flag, compare_one_flag, compare_two_flag, overflow_flag;
wire [7:0] ctrl_one_view, ctrl_two_view, status_view;

// ********************************************************
// bus handshakes and address decode
// ********************************************************
// address and data are taken together, only once the last response is gone
assign wr_take = awvalid && wvalid && !bvalid;
assign awready = wr_take;
assign wready = wr_take;
// a single read is in flight at a time
assign rd_take = arvalid && !rvalid;
assign arready = !rvalid;

// registers are eight bits wide, so only lane 0 carries data
assign wr_lane = wstrb[0];

// word index is compared in full; upper address bits must be zero
assign wr_hit_one = (awaddr[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, `CTRL_ONE_INDEX});
assign wr_hit_two = (awaddr[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, `CTRL_TWO_INDEX});
assign wr_hit_status = (awaddr[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, `STATUS_INDEX});
assign wr_mapped = wr_hit_one || wr_hit_two || wr_hit_status;
assign rd_hit_one = (araddr[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, `CTRL_ONE_INDEX});
assign rd_hit_two = (araddr[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, `CTRL_TWO_INDEX});
assign rd_hit_status = (araddr[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, `STATUS_INDEX});
assign rd_mapped = rd_hit_one || rd_hit_two || rd_hit_status;

// status accesses are the first step of every clear sequence
assign status_read = rd_take && rd_hit_status;
assign status_write = wr_take && wr_hit_status;

// ********************************************************
// write response channel
// ********************************************************
// unmapped writes are answered with a slave error, nothing is stored
always @(posedge aclk) begin
    if (!aresetn) begin
        bvalid <= 1'b0;
        bresp <= `RESP_OKAY;
    end else if (wr_take) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
        bvalid <= 1'b0;
    end
end

// ********************************************************
// control registers
// ********************************************************
// enables, pin enables and levels; reset clears them
always @(posedge aclk) begin
    if (!aresetn) begin
        capture_one_irq_enable <= 1'b0;
        capture_two_irq_enable <= 1'b0;
        compare_one_irq_enable <= 1'b0;
        overflow_irq_enable <= 1'b0;
        compare_one_pin_enable <= 1'b0;
        compare_one_level <= 1'b0;
        compare_two_irq_enable <= CTRL_TWO_RST[`BIT_CMP2_IE];
        compare_two_pin_enable <= CTRL_TWO_RST[`BIT_CMP2_PIN];
        compare_two_level <= CTRL_TWO_RST[`BIT_CMP2_LVL];
    end else if (wr_take && wr_lane) begin
        if (wr_hit_one) begin
            capture_one_irq_enable <= wdata[`BIT_CAP1_IE];
            capture_two_irq_enable <= wdata[`BIT_CAP2_IE];
            compare_one_irq_enable <= wdata[`BIT_CMP1_IE];
            overflow_irq_enable <= wdata[`BIT_OVF_IE];
            compare_one_pin_enable <= wdata[`BIT_CMP1_PIN];
            compare_one_level <= wdata[`BIT_CMP1_LVL];
        end
        if (wr_hit_two) begin
            compare_two_irq_enable <= wdata[`BIT_CMP2_IE];
            compare_two_pin_enable <= wdata[`BIT_CMP2_PIN];
            compare_two_level <= wdata[`BIT_CMP2_LVL];
        end
    end
end

// edge selects sit outside the reset on purpose: software set-up survives a
// reset, and they read as unknown until first written
always @(posedge aclk) begin
    if (wr_take && wr_lane && wr_hit_one) begin
        capture_one_edge_select <= wdata[`BIT_CAP1_EDGE];
        capture_two_edge_select <= wdata[`BIT_CAP2_EDGE];
    end
end

// ********************************************************
// prescaler for the free-running counter
// ********************************************************
// tick is high one cycle in four; the counter steps on that edge
always @(posedge aclk) begin
    if (!aresetn) begin
        prescale <= 2'h0;
        counter_tick <= 1'b0;
    end else begin
        prescale <= prescale + 2'h1;
        counter_tick <= (prescale == `PRESCALE_LAST);
    end
end

// ********************************************************
// capture edge detection
// ********************************************************
edge_detect cap_one_det (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(capture_input_one),
    .rising_sel(capture_one_edge_select),
    .edge_pulse(cap_one_edge)
);

edge_detect cap_two_det (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(capture_input_two),
    .rising_sel(capture_two_edge_select),
    .edge_pulse(cap_two_edge)
);

// latch strobes to the capture registers, one cycle behind the edge pulse
always @(posedge aclk) begin
    if (!aresetn) begin
        capture_one_latch <= 1'b0;
        capture_two_latch <= 1'b0;
    end else begin
        capture_one_latch <= cap_one_edge;
        capture_two_latch <= cap_two_edge;
    end
end

// ********************************************************
// compare inhibit and match
// ********************************************************
// high byte write blocks matching until the low byte follows; a low write
// alone never blocks, and a low write in the same cycle lets the high win
always @(posedge aclk) begin
    if (!aresetn) begin
        compare_one_inhibit <= 1'b0;
        compare_two_inhibit <= 1'b0;
    end else begin
        if (compare_one_high_write) begin
            compare_one_inhibit <= 1'b1;
        end else if (compare_one_low_write) begin
            compare_one_inhibit <= 1'b0;
        end
        if (compare_two_high_write) begin
            compare_two_inhibit <= 1'b1;
        end else if (compare_two_low_write) begin
            compare_two_inhibit <= 1'b0;
        end
    end
end

// compared once per count so a match fires a single time
assign cmp_one_match = counter_tick && compare_one_equal && !compare_one_inhibit;
assign cmp_two_match = counter_tick && compare_two_equal && !compare_two_inhibit;

// output level registers follow the level bits on every match
always @(posedge aclk) begin
    if (!aresetn) begin
        compare_output_one <= 1'b0;
        compare_output_two <= 1'b0;
        compare_output_one_oe <= 1'b0;
        compare_output_two_oe <= 1'b0;
    end else begin
        if (cmp_one_match) begin
            compare_output_one <= compare_one_level;
        end
        if (cmp_two_match) begin
            compare_output_two <= compare_two_level;
        end
        compare_output_one_oe <= compare_one_pin_enable;
        compare_output_two_oe <= compare_two_pin_enable;
    end
end

// ********************************************************
// status flags
// ********************************************************
status_flag cap_one_flag_cell (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_event(cap_one_edge),
    .arm_access(status_read),
    .clear_access(capture_one_low_read),
    .flag(capture_one_flag)
);

status_flag cap_two_flag_cell (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_event(cap_two_edge),
    .arm_access(status_read),
    .clear_access(capture_two_low_read),
    .flag(capture_two_flag)
);

status_flag cmp_one_flag_cell (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_event(cmp_one_match),
    .arm_access(status_read),
    .clear_access(compare_one_low_write),
    .flag(compare_one_flag)
);

status_flag cmp_two_flag_cell (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_event(cmp_two_match),
    .arm_access(status_read),
    .clear_access(compare_two_low_write),
    .flag(compare_two_flag)
);

// writes arm too, so stray counter reads can swallow an overflow;
// the alternate counter has no strobe here and cannot clear it
status_flag ovf_flag_cell (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_event(counter_wrap),
    .arm_access(status_read || status_write),
    .clear_access(counter_low_read),
    .flag(overflow_flag)
);

// ********************************************************
// interrupt request
// ********************************************************
// registered, so it trails the flag by one cycle
always @(posedge aclk) begin
    if (!aresetn) begin
        timer_irq <= 1'b0;
    end else begin
        timer_irq <= (capture_one_flag && capture_one_irq_enable) ||
                     (capture_two_flag && capture_two_irq_enable) ||
                     (compare_one_flag && compare_one_irq_enable) ||
                     (compare_two_flag && compare_two_irq_enable) ||
                     (overflow_flag && overflow_irq_enable);
    end
end

// ********************************************************
// read views and read channel
// ********************************************************
assign ctrl_one_view = {capture_one_irq_enable, capture_two_irq_enable, compare_one_irq_enable,
                        overflow_irq_enable, compare_one_pin_enable, capture_one_edge_select,
                        capture_two_edge_select, compare_one_level};
// unused positions are wired to zero
assign ctrl_two_view = {2'b00, compare_two_irq_enable, 1'b0, compare_two_pin_enable, 2'b00,
                        compare_two_level};
// pin levels are shown live, not latched
assign status_view = {capture_one_flag, capture_two_flag, compare_one_flag, overflow_flag,
                      capture_input_one, capture_input_two, compare_two_flag, 1'b0};

// read mux
always @* begin
    next_rdata = 8'h00;
    if (rd_hit_one) begin
        next_rdata = ctrl_one_view;
    end else if (rd_hit_two) begin
        next_rdata = ctrl_two_view;
    end else if (rd_hit_status) begin
        next_rdata = status_view;
    end
end

// read data is captured at the address edge; unmapped reads give zero and an error
always @(posedge aclk) begin
    if (!aresetn) begin
        rvalid <= 1'b0;
        rdata <= 32'h00000000;
        rresp <= `RESP_OKAY;
    end else if (rd_take) begin
        rvalid <= 1'b1;
        rdata <= {24'h000000, next_rdata};
        rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
        rvalid <= 1'b0;
    end
end

endmodule // timer_capture_compare_ctrl

// [bench/timer_capture_compare_ctrl_chk.sv]
`timescale 1ns/10ps
// ********************************************************
// port timing checks for the timer control block
// ********************************************************
module timer_capture_compare_ctrl_chk (
    input wire aclk,
    input wire aresetn,
    input wire awvalid,
    input wire wvalid,
    input wire awready,
    input wire bvalid,
    input wire bready,
    input wire arvalid,
    input wire arready,
    input wire rvalid,
    input wire capture_input_one,
    input wire capture_input_two,
    input wire capture_one_latch,
    input wire capture_two_latch,
    input wire compare_one_equal,
    input wire compare_two_equal,
    input wire counter_tick,
    input wire compare_output_one,
    input wire compare_output_two,
    input wire compare_output_one_oe,
    input wire compare_output_two_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_write_answer;
        awvalid && wvalid && awready |=> bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write answer missing");
    // a taken answer must go away; a stuck bvalid would answer twice
    property p_write_drop;
        bvalid && bready |=> !bvalid;
    endproperty
    a_write_drop: assert property (p_write_drop) else $error("write answer repeated");
    property p_read_answer;
        arvalid && arready |=> rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer missing");
    property p_tick_period;
        counter_tick |=> !counter_tick [*3] ##1 counter_tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("prescaler period wrong");
    property p_level_one;
        $changed(compare_output_one) |-> $past(counter_tick) && $past(compare_one_equal);
    endproperty
    a_level_one: assert property (p_level_one) else $error("output one moved without match");
    property p_level_two;
        $changed(compare_output_two) |-> $past(counter_tick) && $past(compare_two_equal);
    endproperty
    a_level_two: assert property (p_level_two) else $error("output two moved without match");
    // the pin enable trails the register bit by one cycle
    property p_pin_enable_one;
        $changed(compare_output_one_oe) |-> $past(awvalid && awready, 2);
    endproperty
    a_pin_enable_one: assert property (p_pin_enable_one) else $error("enable one moved alone");
    property p_pin_enable_two;
        $changed(compare_output_two_oe) |-> $past(awvalid && awready, 2);
    endproperty
    a_pin_enable_two: assert property (p_pin_enable_two) else $error("enable two moved alone");
    property p_latch_one;
        capture_one_latch |-> $past(capture_input_one, 2) != $past(capture_input_one, 3);
    endproperty
    a_latch_one: assert property (p_latch_one) else $error("latch one without pin edge");
    property p_latch_two;
        capture_two_latch |-> $past(capture_input_two, 2) != $past(capture_input_two, 3);
    endproperty
    a_latch_two: assert property (p_latch_two) else $error("latch two without pin edge");
endmodule // timer_capture_compare_ctrl_chk

// [bench/capture_pin_model.sv]
`timescale 1ns/10ps
// ********************************************************
// far side: capture lines and compare pins with pull-ups
// ********************************************************
module capture_pin_model (
    input wire [1:0] pull_low,
    input wire [1:0] drive_level,
    input wire [1:0] drive_enable,
    output wire capture_input_one,
    output wire capture_input_two,
    output wire [1:0] pin_level
);
    // capture lines idle high; only an external driver pulls them low
    assign capture_input_one = ~pull_low[0];
    assign capture_input_two = ~pull_low[1];
    // an undriven compare pin floats up, so a stale level never shows
    assign pin_level = (drive_enable & drive_level) | ~drive_enable;
endmodule // capture_pin_model

// [bench/test_timer_capture_compare_ctrl.sv]
`timescale 1ns/10ps
`include "timer_ccr_defs.vh"
module test_timer_capture_compare_ctrl;
    localparam logic [11:0] CTRL1 = {2'h0, `CTRL_ONE_INDEX, 2'h0};
    localparam logic [11:0] CTRL2 = {2'h0, `CTRL_TWO_INDEX, 2'h0};
    localparam logic [11:0] STAT = {2'h0, `STATUS_INDEX, 2'h0};
    typedef struct packed {logic [11:0] addr; logic [7:0] wd; logic [7:0] exp; logic [1:0] rsp;} reg_row;
    reg_row rows [5] = '{'{CTRL1, 8'hFF, 8'hFF, `RESP_OKAY}, '{CTRL1, 8'h00, 8'h00, `RESP_OKAY},
        '{CTRL2, 8'hFF, 8'h29, `RESP_OKAY}, '{CTRL2, 8'h00, 8'h00, `RESP_OKAY}, '{12'h0BC, 8'h5A, 8'h00, `RESP_SLVERR}};
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] pull_low = 2'h0, equal_in = 2'h0, resp;
    logic [7:0] strobes = 8'h00, got;
    wire awready, wready, bvalid, arready, rvalid, capture_input_one, capture_input_two;
    wire capture_one_latch, capture_two_latch, counter_tick, timer_irq;
    wire [1:0] bresp, rresp, cmp_out, cmp_oe, pin_level;
    wire [31:0] rdata;
    int bad_count = 0, checked = 0, cycles = 0;

    timer_capture_compare_ctrl #(.ADDR_W(12)) DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .capture_input_one, .capture_input_two, .capture_one_latch, .capture_two_latch,
        .compare_one_equal(equal_in[0]), .compare_two_equal(equal_in[1]), .compare_one_high_write(strobes[0]),
        .compare_two_high_write(strobes[1]), .compare_one_low_write(strobes[2]), .compare_two_low_write(strobes[3]),
        .capture_one_low_read(strobes[4]), .capture_two_low_read(strobes[5]), .counter_low_read(strobes[6]),
        .counter_wrap(strobes[7]), .counter_tick, .compare_output_one(cmp_out[0]), .compare_output_one_oe(cmp_oe[0]),
        .compare_output_two(cmp_out[1]), .compare_output_two_oe(cmp_oe[1]), .timer_irq);
    capture_pin_model u_pins (.pull_low, .drive_level(cmp_out), .drive_enable(cmp_oe), .capture_input_one,
        .capture_input_two, .pin_level);

    always #25 aclk = ~aclk;
    // ********************************************************
    // shared tasks
    // ********************************************************
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // a hung handshake is cut off here rather than stalling the run
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic aw_done, w_done;
        @(posedge aclk);
        aw_done = 1'h0;
        w_done = 1'h0;
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        // each channel is released at the edge where its own ready is seen
        do begin
            @(posedge aclk);
            if (awready === 1'h1) begin
                awvalid <= 1'h0;
                aw_done = 1'h1;
            end
            if (wready === 1'h1) begin
                wvalid <= 1'h0;
                w_done = 1'h1;
            end
        end while (!(aw_done && w_done));
        do @(posedge aclk); while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        got = rdata[7:0];
        resp = rresp;
        rready <= 1'h0;
    endtask
    task automatic pulse(input logic [7:0] m);
        @(posedge aclk);
        strobes <= m;
        @(posedge aclk);
        strobes <= 8'h00;
    endtask
    // eight cycles of equality always span two prescaler ticks
    task automatic match(input int i);
        @(posedge aclk);
        equal_in[i] <= 1'h1;
        repeat (8) @(posedge aclk);
        equal_in[i] <= 1'h0;
        repeat (2) @(posedge aclk);
    endtask
    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        logic [11:0] ca;
        logic [7:0] fm;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (rows[n]) begin
            wr(rows[n].addr, rows[n].wd);
            check("write resp", {6'h0, rows[n].rsp}, {6'h0, resp});
            rd(rows[n].addr);
            check("read data", rows[n].exp, got);
            check("read resp", {6'h0, rows[n].rsp}, {6'h0, resp});
        end
        $display("register table done");
        // capture one on rising edge, capture two on falling edge
        for (int i = 0; i < 2; i++) begin
            wr(CTRL1, i ? 8'h40 : 8'h84);
            @(posedge aclk) pull_low[i] <= 1'h1;
            repeat (4) @(posedge aclk);
            rd(STAT);
            check("flag on low edge", i ? 8'h40 : 8'h00, got & (8'h80 >> i));
            check("pin level low", 8'h00, got & (8'h08 >> i));
            @(posedge aclk) pull_low[i] <= 1'h0;
            repeat (4) @(posedge aclk);
            rd(STAT);
            check("capture flag", 8'h80 >> i, got & (8'h80 >> i));
            check("pin level high", 8'h08 >> i, got & (8'h08 >> i));
            check("capture irq", 8'h01, {7'h0, timer_irq});
            pulse(8'h10 << i);
            rd(STAT);
            check("capture clear", 8'h00, got & (8'h80 >> i));
            check("irq released", 8'h00, {7'h0, timer_irq});
        end
        $display("capture done");
        for (int i = 0; i < 2; i++) begin
            ca = i ? CTRL2 : CTRL1;
            fm = i ? 8'h02 : 8'h20;
            wr(ca, 8'h29);
            match(i);
            rd(STAT);
            check("compare flag", fm, got & fm);
            check("compare pin high", 8'h01, {7'h0, pin_level[i]});
            check("compare irq", 8'h01, {7'h0, timer_irq});
            pulse(8'h01 << i);
            wr(ca, 8'h28);
            match(i);
            check("inhibited", 8'h01, {7'h0, cmp_out[i]});
            pulse(8'h04 << i);
            match(i);
            check("compare pin low", 8'h00, {7'h0, pin_level[i]});
            rd(STAT);
            pulse(8'h04 << i);
            rd(STAT);
            check("compare clear", 8'h00, got & fm);
            wr(ca, 8'h00);
            repeat (2) @(posedge aclk);
            check("pin released", 8'h01, {7'h0, pin_level[i]});
        end
        $display("compare done");
        wr(CTRL1, 8'h10);
        pulse(8'h80);
        repeat (3) @(posedge aclk);
        check("overflow irq", 8'h01, {7'h0, timer_irq});
        pulse(8'h40);
        repeat (3) @(posedge aclk);
        check("unarmed read", 8'h01, {7'h0, timer_irq});
        wr(STAT, 8'h00);
        check("status write resp", 8'h00, {6'h0, resp});
        pulse(8'h40);
        rd(STAT);
        check("write armed clear", 8'h00, got & 8'h10);
        pulse(8'h80);
        rd(STAT);
        pulse(8'hC0);
        rd(STAT);
        check("set beats clear", 8'h10, got & 8'h10);
        pulse(8'h40);
        rd(STAT);
        check("overflow clear", 8'h00, got & 8'h10);
        $display("overflow done");
        wr(CTRL1, 8'h0E);
        wr(CTRL2, 8'h29);
        repeat (2) @(posedge aclk);
        check("pin enable", 8'h01, {7'h0, cmp_oe[0]});
        check("pin enable two", 8'h01, {7'h0, cmp_oe[1]});
        aresetn <= 1'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        check("enable reset", 8'h00, {7'h0, cmp_oe[0]});
        check("enable two reset", 8'h00, {7'h0, cmp_oe[1]});
        rd(CTRL1);
        check("edge selects kept", 8'h06, got);
        rd(CTRL2);
        check("control two reset", 8'h00, got);
        rd(STAT);
        check("status after reset", 8'h0C, got);
        $display("reset done");
        stop_test();
    end
endmodule // test_timer_capture_compare_ctrl

bind timer_capture_compare_ctrl timer_capture_compare_ctrl_chk u_chk (.aclk, .aresetn, .awvalid, .wvalid, .bready,
    .awready, .bvalid, .arvalid, .arready, .rvalid, .capture_input_one, .capture_input_two, .capture_one_latch,
    .capture_two_latch, .compare_one_equal, .compare_two_equal, .counter_tick, .compare_output_one,
    .compare_output_two, .compare_output_one_oe, .compare_output_two_oe);
